// ===== pkg/ecl_consts.vh
// Purpose: Constants for the EEPROM configuration loader
// Assumes: 40 MHz core clock
// Notes:   Definitions only
`ifndef ECL_CONSTS_VH
`define ECL_CONSTS_VH
`define ECL_CLK_MHZ        40
`define ECL_SCL_KHZ        100
`define ECL_QTR_CYC        ((`ECL_CLK_MHZ * 1000) / (`ECL_SCL_KHZ * 4))
`define ECL_ACK_TO_US      1000
`define ECL_ACK_TO_CYC     (`ECL_ACK_TO_US * `ECL_CLK_MHZ)
`define ECL_SLAVE_HI       4'b1010
`define ECL_SIG0           8'hEE
`define ECL_SIG1           8'hC0
`define ECL_SIG2           8'hDE
`define ECL_SIG3           8'h1F
`define ECL_NO_CCR         16'hFFFF
`define ECL_CSR_RECORD_IDENTIFIER       4
`define ECL_CSR_PTRHI      6
`define ECL_CSR_PTRLO      7
`define ECL_CSR_LEN        8
`define ECL_FIFO_DEPTH     16
`endif

// ===== verilog/ecl_fifo.v
// Purpose: Small synchronous FIFO for loaded configuration entries
// Assumes: One clock, depth a power of two
// Notes:   Read data come out of a register
`timescale 1ns/1ps
module ecl_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output reg              outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_q;
    reg [AW:0]      rdPtr_q;
    wire            empty = (wrPtr_q == rdPtr_q);
    wire            full  = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
    wire            pop   = !empty && (!outValid || outReady);

    assign inReady = !full;

    // Storage write; no reset needed for data
    always @(posedge clk) begin
        if (inValid && !full) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    // Pointers and registered output stage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q  <= {(AW+1){1'b0}};
            rdPtr_q  <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData  <= {WIDTH{1'b0}};
        end else begin
            if (inValid && !full) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                outData  <= mem[rdPtr_q[AW-1:0]];
                outValid <= 1'b1;
                rdPtr_q  <= rdPtr_q + 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end
endmodule

// ===== verilog/ecl_loader.v
// Functional notes
// - First byte at content record is entry count; 00 means one, FF 256.
// - Each entry is three bytes: register address, data high, data low.
// - Offsets are byte addresses; layout independent of addressing mode.
// - Strap selects 11-bit or 16-bit addressing; never mixed.
// - Only 7-bit slave addresses are sent.
// - Slave address is 1010 plus three strap bits or address bits.
// - 11-bit mode sends one address byte, high bits go in slave address.
// - Size selects how many strap bits are replaced by address bits 10:8.
// - Write frame: START, address/W, memory address, data, STOP after ack.
// - Only single random-address byte writes, never page writes.
// - Random read: dummy write to address, repeated START, address/R.
// - Single read leaves data byte unacknowledged, then STOP.
// - Burst read acks each byte; ends with no-ack and STOP.
// - Burst only for firmware load; configuration uses single reads.
// - After reset sample SDA: high means EEPROM present.
// - No ack on probe read before timeout aborts: no EEPROM.
// - Signature searched at multiples of step, default size divided by 64.
// - Content pointer FFFF means no content record; nothing loaded.
//
// Purpose: I2C master that finds and loads configuration entries from EEPROM
// Assumes: 40 MHz clk, SDA/SCL open drain, straps stable at reset release
// Notes:   Burst reads are not used since firmware loading is out of scope
`timescale 1ns/1ps
`include "ecl_consts.vh"
module ecl_loader #(
    parameter QTR_CYC    = `ECL_QTR_CYC,
    parameter ACK_TO_CYC = `ECL_ACK_TO_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        strapAddr16,
    input  wire [2:0]  slaveSelectBits,
    input  wire [3:0]  strapSize,
    input  wire [3:0]  strapStep,
    input  wire [2:0]  strapRecordId,
    input  wire        sdaIn,
    output reg         sdaOut,
    output reg         sdaOe,
    input  wire        sclIn,
    output reg         sclOut,
    output reg         sclOe,
    output reg         mgmtWrValid,
    input  wire        mgmtWrReady,
    output reg  [7:0]  mgmtWrAddr,
    output reg  [15:0] mgmtWrData,
    output reg         eepromPresent,
    output reg         loadDone,
    output reg         loadError
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg sdaS1_q, sdaS2_q, sclS1_q, sclS2_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaS1_q <= 1'b1;
            sdaS2_q <= 1'b1;
            sclS1_q <= 1'b1;
            sclS2_q <= 1'b1;
        end else begin
            sdaS1_q <= sdaIn;
            sdaS2_q <= sdaS1_q;
            sclS1_q <= sclIn;
            sclS2_q <= sclS1_q;
        end
    end

    // ------------------------------------------------------------------
    // Quarter-bit enable divider
    // ------------------------------------------------------------------
    reg [15:0] divCnt_q;
    reg        tick_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 16'h0000;
            tick_q   <= 1'b0;
        end else if (divCnt_q == QTR_CYC - 1) begin
            divCnt_q <= 16'h0000;
            tick_q   <= 1'b1;
        end else begin
            divCnt_q <= divCnt_q + 16'h0001;
            tick_q   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Slave byte for 11-bit mode: size code 0..4 means 1,2,4,8,16 kb
    function [7:0] slaveByte;
        input        addr16;
        input [3:0]  size;
        input [2:0]  sel;
        input [15:0] adr;
        input        rd;
        reg   [2:0]  low;
        begin
            low = sel;
            if (!addr16) begin
                if (size == 4'd2) low = {sel[2:1], adr[8]};
                else if (size == 4'd3) low = {sel[2], adr[9:8]};
                else if (size >= 4'd4) low = adr[10:8];
            end
            slaveByte = {`ECL_SLAVE_HI, low, rd};
        end
    endfunction

    // Step in bytes: default is EEPROM bytes / 64, i.e. 2 << size
    function [15:0] stepBytes;
        input [3:0] size;
        input [3:0] step;
        begin
            if (step == 4'h0) stepBytes = 16'h0002 << size;
            else stepBytes = 16'h0001 << step;
        end
    endfunction

    // ------------------------------------------------------------------
    // Byte-level I2C engine
    // ------------------------------------------------------------------
    localparam B_IDLE = 3'd0, B_START = 3'd1, B_BIT = 3'd2, B_ACK = 3'd3;
    localparam B_STOP = 3'd4, B_DONE = 3'd5;
    reg [2:0]  bst_q;
    reg [1:0]  ph_q;
    reg [2:0]  bitIdx_q;
    reg [7:0]  shift_q;
    reg        isRead_q;
    reg        ackOut_q;
    reg        stopAfter_q;
    reg        gotAck_q;
    reg        byteGo_q;
    reg        byteStart_q;
    reg        byteDone_q;
    reg [7:0]  loadByte_q;
    wire       sclHigh = sclS2_q;

    // Four-phase bit engine: phases 0/1 SCL low, 2/3 SCL high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bst_q <= B_IDLE; ph_q <= 2'd0; bitIdx_q <= 3'd0; shift_q <= 8'h00;
            sdaOut <= 1'b0; sdaOe <= 1'b0; sclOut <= 1'b0; sclOe <= 1'b0;
            gotAck_q <= 1'b0; byteDone_q <= 1'b0; loadByte_q <= 8'h00;
        end else begin
            byteDone_q <= 1'b0;
            case (bst_q)
                B_IDLE: begin
                    if (byteGo_q) begin
                        bst_q <= byteStart_q ? B_START : B_BIT;
                        shift_q <= loadByte_q;
                        ph_q <= 2'd0;
                        bitIdx_q <= 3'd7;
                    end else if (loadError) begin
                        {sdaOe, sclOe} <= 2'b00; // Abort frees the bus
                    end
                end
                B_START: if (tick_q) begin // Repeated START too
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) begin sdaOe <= 1'b0; end
                    if (ph_q == 2'd1) begin sclOe <= 1'b0; end
                    if (ph_q == 2'd2) begin sdaOe <= 1'b1; end
                    if (ph_q == 2'd3) begin sclOe <= 1'b1; bst_q <= B_BIT; end
                end
                B_BIT: if (tick_q) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) sdaOe <= isRead_q ? 1'b0 : !shift_q[7];
                    if (ph_q == 2'd1) sclOe <= 1'b0;
                    if (ph_q == 2'd2 && !sclHigh) ph_q <= ph_q; // Clock stretch
                    if (ph_q == 2'd3) begin
                        sclOe <= 1'b1;
                        shift_q <= {shift_q[6:0], sdaS2_q};
                        if (bitIdx_q == 3'd0) bst_q <= B_ACK;
                        else bitIdx_q <= bitIdx_q - 3'd1;
                    end
                end
                B_ACK: if (tick_q) begin
                    ph_q <= ph_q + 2'd1;
                    // Data reads: ack drives low, no-ack releases
                    if (ph_q == 2'd0) sdaOe <= isRead_q ? ackOut_q : 1'b0;
                    if (ph_q == 2'd1) sclOe <= 1'b0;
                    if (ph_q == 2'd2 && !sclHigh) ph_q <= ph_q;
                    if (ph_q == 2'd3) begin
                        sclOe <= 1'b1;
                        gotAck_q <= !sdaS2_q;
                        bst_q <= stopAfter_q ? B_STOP : B_DONE;
                    end
                end
                B_STOP: if (tick_q) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) sdaOe <= 1'b1;
                    if (ph_q == 2'd1) sclOe <= 1'b0;
                    if (ph_q == 2'd3) begin sdaOe <= 1'b0; bst_q <= B_DONE; end
                end
                B_DONE: begin
                    byteDone_q <= 1'b1;
                    bst_q <= B_IDLE;
                end
                default: bst_q <= B_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Entry FIFO towards the management register port
    // ------------------------------------------------------------------
    reg         fInValid_q;
    reg  [23:0] fInData_q;
    wire        fInReady;
    wire        fOutValid;
    wire [23:0] fOutData;
    ecl_fifo #(.WIDTH(24), .DEPTH(`ECL_FIFO_DEPTH), .AW(4)) uFifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (fInValid_q),
        .inReady  (fInReady),
        .inData   (fInData_q),
        .outValid (fOutValid),
        .outReady (!mgmtWrValid || mgmtWrReady),
        .outData  (fOutData)
    );
    // Registered write port, entries leave in record order
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mgmtWrValid <= 1'b0; mgmtWrAddr <= 8'h00; mgmtWrData <= 16'h0000;
        end else if (!mgmtWrValid || mgmtWrReady) begin
            mgmtWrValid <= fOutValid;
            mgmtWrAddr  <= fOutData[23:16];
            mgmtWrData  <= fOutData[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Loader sequencer: one single-byte random read per byte
    // ------------------------------------------------------------------
    localparam S_BOOT = 4'd0, S_RD_SLW = 4'd1, S_RD_AHI = 4'd2, S_RD_ALO = 4'd3;
    localparam S_RD_SLR = 4'd4, S_RD_DAT = 4'd5, S_WAIT = 4'd6, S_NEXT = 4'd7;
    localparam S_PUSH = 4'd8, S_DONE = 4'd9, S_FAIL = 4'd10;
    localparam P_SIG = 2'd0, P_CCR = 2'd1;
    reg [3:0]  st_q, ret_q;
    reg [1:0]  pass_q;
    reg [15:0] adr_q, base_q, ptr_q;
    reg [3:0]  idx_q;
    reg [8:0]  entLeft_q;
    reg [1:0]  entByte_q;
    reg [15:0] entHold_q;
    reg [31:0] toCnt_q;
    reg        probed_q;
    reg        mode16_q;
    wire [15:0] sizeBytes = 16'h0080 << strapSize;

    // Queue one byte for the bit engine
    task shift_q_load(input [7:0] b, input s, input p);
        begin
            loadByte_q  <= b;
            byteStart_q <= s;
            stopAfter_q <= p;
            byteGo_q    <= 1'b1;
        end
    endtask

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_BOOT; ret_q <= S_BOOT; pass_q <= P_SIG; adr_q <= 16'h0000;
            base_q <= 16'h0000; ptr_q <= 16'h0000; idx_q <= 4'h0; entLeft_q <= 9'h000;
            entByte_q <= 2'd0; entHold_q <= 16'h0000; toCnt_q <= 32'h0000_0000;
            probed_q <= 1'b0; mode16_q <= 1'b0; byteGo_q <= 1'b0; byteStart_q <= 1'b0;
            isRead_q <= 1'b0; ackOut_q <= 1'b0; stopAfter_q <= 1'b0;
            fInValid_q <= 1'b0; fInData_q <= 24'h00_0000;
            eepromPresent <= 1'b0; loadDone <= 1'b0; loadError <= 1'b0;
        end else begin
            byteGo_q <= 1'b0;
            fInValid_q <= fInValid_q && !fInReady;
            case (st_q)
                S_BOOT: if (tick_q) begin // Synchronisers filled
                    mode16_q <= strapAddr16; // Latched once, never mixed
                    if (sdaS2_q) begin
                        eepromPresent <= 1'b1;
                        st_q <= S_RD_SLW;
                    end else begin
                        st_q <= S_DONE;
                    end
                end
                S_RD_SLW: begin // Dummy write start
                    shift_q_load(slaveByte(mode16_q, strapSize, slaveSelectBits, adr_q, 1'b0),
                                 1'b1, 1'b0);
                    ret_q <= mode16_q ? S_RD_AHI : S_RD_ALO;
                    st_q <= S_WAIT;
                end
                S_RD_AHI: begin
                    shift_q_load(adr_q[15:8], 1'b0, 1'b0);
                    ret_q <= S_RD_ALO; st_q <= S_WAIT;
                end
                S_RD_ALO: begin
                    shift_q_load(adr_q[7:0], 1'b0, 1'b0);
                    ret_q <= S_RD_SLR; st_q <= S_WAIT;
                end
                S_RD_SLR: begin // Repeated START with read bit
                    shift_q_load(slaveByte(mode16_q, strapSize, slaveSelectBits, adr_q, 1'b1),
                                 1'b1, 1'b0);
                    ret_q <= S_RD_DAT; st_q <= S_WAIT;
                end
                S_RD_DAT: begin // No ack then STOP
                    shift_q_load(8'hFF, 1'b0, 1'b1);
                    isRead_q <= 1'b1;
                    ret_q <= S_NEXT; st_q <= S_WAIT;
                end
                S_WAIT: begin
                    toCnt_q <= toCnt_q + 32'h0000_0001;
                    if (byteDone_q) begin
                        toCnt_q <= 32'h0000_0000;
                        isRead_q <= 1'b0;
                        if (!isRead_q && !gotAck_q) begin
                            st_q <= S_FAIL;
                        end else begin
                            probed_q <= 1'b1;
                            st_q <= ret_q;
                        end
                    end else if (toCnt_q >= ACK_TO_CYC) begin
                        st_q <= S_FAIL;
                    end
                end
                S_NEXT: begin
                    st_q <= S_RD_SLW;
                    if (pass_q == P_SIG) begin
                        idx_q <= idx_q + 4'h1;
                        adr_q <= base_q + {12'h000, idx_q} + 16'h0001;
                        if (idx_q == 4'd0 && shift_q != `ECL_SIG0) idx_q <= 4'hF;
                        if (idx_q == 4'd1 && shift_q != `ECL_SIG1) idx_q <= 4'hF;
                        if (idx_q == 4'd2 && shift_q != `ECL_SIG2) idx_q <= 4'hF;
                        if (idx_q == 4'd3 && shift_q != `ECL_SIG3) idx_q <= 4'hF;
                        if (idx_q == `ECL_CSR_RECORD_IDENTIFIER && shift_q[2:0] != strapRecordId)
                            idx_q <= 4'hF;
                        if (idx_q == `ECL_CSR_PTRHI) ptr_q[15:8] <= shift_q;
                        if (idx_q == `ECL_CSR_PTRLO) begin
                            ptr_q[7:0] <= shift_q;
                            if ({ptr_q[15:8], shift_q} == `ECL_NO_CCR) begin
                                st_q <= S_DONE;
                            end else begin
                                pass_q <= P_CCR; entByte_q <= 2'd3;
                                adr_q <= {ptr_q[15:8], shift_q};
                            end
                        end
                        if (idx_q == 4'hF || idx_q == `ECL_CSR_LEN) begin
                            idx_q <= 4'h0;
                            base_q <= base_q + stepBytes(strapSize, strapStep);
                            adr_q <= base_q + stepBytes(strapSize, strapStep);
                            if (base_q + stepBytes(strapSize, strapStep) >= sizeBytes)
                                st_q <= S_DONE;
                        end
                    end else begin
                        adr_q <= adr_q + 16'h0001;
                        if (entByte_q == 2'd3) begin
                            entLeft_q <= {1'b0, shift_q} + 9'h001;
                            entByte_q <= 2'd0;
                        end else if (entByte_q == 2'd2) begin
                            fInData_q <= {entHold_q, shift_q};
                            st_q <= S_PUSH;
                        end else begin
                            entHold_q <= {entHold_q[7:0], shift_q};
                            entByte_q <= entByte_q + 2'd1;
                        end
                    end
                end
                S_PUSH: if (!fInValid_q) begin // Back-pressure from the FIFO
                    fInValid_q <= 1'b1;
                    entByte_q <= 2'd0;
                    entLeft_q <= entLeft_q - 9'h001;
                    st_q <= (entLeft_q == 9'h001) ? S_DONE : S_RD_SLW;
                end
                S_DONE: loadDone <= 1'b1;
                S_FAIL: begin
                    eepromPresent <= probed_q;
                    loadError <= 1'b1;
                    loadDone <= loadError; // Set one cycle after loadError is set
                end
                default: st_q <= S_DONE;
            endcase
        end
    end
endmodule

// ===== dv/ecl_loader_chk.sv
// Purpose: Port checker for the EEPROM configuration loader
// Assumes: Open-drain bus levels seen on sdaIn and sclIn
// Notes:   Frame position is tracked from START, STOP and SCL rises
`timescale 1ns/1ps
module ecl_loader_chk #(
    parameter QTR_CYC    = 2,
    parameter ACK_TO_CYC = 2000
) (
    input wire        clk,
    input wire        rst_n,
    input wire        strapAddr16,
    input wire [2:0]  slaveSelectBits,
    input wire [3:0]  strapSize,
    input wire [3:0]  strapStep,
    input wire [2:0]  strapRecordId,
    input wire        sdaIn,
    input wire        sdaOut,
    input wire        sdaOe,
    input wire        sclIn,
    input wire        sclOut,
    input wire        sclOe,
    input wire        mgmtWrValid,
    input wire        mgmtWrReady,
    input wire [7:0]  mgmtWrAddr,
    input wire [15:0] mgmtWrData,
    input wire        eepromPresent,
    input wire        loadDone,
    input wire        loadError
);
    reg       scl_q, sda_q, inFrame_q, rep_q, rw_q;
    reg [3:0] bitCnt_q, byteCnt_q;
    reg [7:0] shift_q;
    wire      startEv = scl_q & sclIn & sda_q & ~sdaIn;
    wire      stopEv  = scl_q & sclIn & ~sda_q & sdaIn;
    wire      sclRise = ~scl_q & sclIn & inFrame_q;
    wire      ackSlot = sclRise & (bitCnt_q == 4'd8);
    // Bit and byte position in the frame; rep_q marks a START without STOP
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_q, sda_q, inFrame_q, rep_q, rw_q} <= 5'h1_F;
            {bitCnt_q, byteCnt_q, shift_q} <= 16'h0000;
        end else begin
            scl_q <= sclIn;
            sda_q <= sdaIn;
            if (startEv) begin
                {bitCnt_q, byteCnt_q} <= 8'h00;
                rep_q <= inFrame_q;
                inFrame_q <= 1'b1;
            end else if (stopEv) begin
                inFrame_q <= 1'b0;
            end else if (sclRise) begin
                bitCnt_q <= ackSlot ? 4'd0 : bitCnt_q + 4'd1;
                byteCnt_q <= byteCnt_q + {3'd0, ackSlot};
                if (!ackSlot) shift_q <= {shift_q[6:0], sdaIn};
                if (bitCnt_q == 4'd7 && byteCnt_q == 4'd0) rw_q <= sdaIn;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_instr;
        ackSlot && (byteCnt_q == 4'd0);
    endsequence
    sequence s_dataAck;
        ackSlot && rw_q && (byteCnt_q != 4'd0);
    endsequence
    a_slave_hi: assert property (s_instr |-> shift_q[7:4] == 4'b1010)
        else $error("slave address upper bits wrong");
    a_rep_start: assert property (s_instr and shift_q[0] |-> rep_q)
        else $error("read instruction without repeated start");
    a_rd_noack: assert property (s_dataAck |-> sdaIn)
        else $error("read data byte acknowledged");
    a_rd_single: assert property (sclRise && rw_q && byteCnt_q != 4'd0 && |bitCnt_q
        |-> byteCnt_q == 4'd1)
        else $error("more than one byte read in a frame");
    a_wr_len: assert property (sclRise && !rw_q && byteCnt_q != 4'd0 && !strapAddr16 && |bitCnt_q
        |-> byteCnt_q < 4'd3)
        else $error("write frame longer than three bytes");
    a_mgmt_hold: assert property (mgmtWrValid && !mgmtWrReady
        |=> mgmtWrValid && $stable(mgmtWrAddr) && $stable(mgmtWrData))
        else $error("entry changed while stalled");
    a_err_quiet: assert property (loadError |-> !mgmtWrValid)
        else $error("entry offered after abort");
    a_absent_idle: assert property (loadDone && !eepromPresent |-> !sdaOe && !sclOe)
        else $error("bus driven with no memory present");
endmodule
bind ecl_loader ecl_loader_chk #(.QTR_CYC(QTR_CYC), .ACK_TO_CYC(ACK_TO_CYC)) chk_u (.*);

// ===== dv/ecl_eeprom_model.sv
// Purpose: Behavioural two-wire EEPROM, 256 bytes, single address byte
// Assumes: Master changes SDA only while SCL is low
// Notes:   mute withholds every acknowledge to model a dead part
`timescale 1ns/1ps
module ecl_eeprom_model (
    input  wire scl,
    input  wire sda,
    input  wire mute,
    output reg  holdLow
);
    reg [7:0] mem [0:255];
    reg [7:0] shift_q, ptr_q;
    reg [3:0] bitCnt_q;
    reg [2:0] state_q;
    initial begin
        holdLow = 1'b0;
        state_q = 3'd0;
        bitCnt_q = 4'd0;
        ptr_q = 8'h00;
    end
    // START or repeated START restarts decoding; STOP ends it
    always @(negedge sda) if (scl) begin
        state_q = 3'd1;
        bitCnt_q = 4'd0;
        holdLow = 1'b0;
    end
    always @(posedge sda) if (scl) state_q = 3'd0;
    // Shift bits in; after each read byte the address moves on
    always @(posedge scl) if (state_q != 3'd0) begin
        if (bitCnt_q < 4'd8) begin
            shift_q = {shift_q[6:0], sda};
            bitCnt_q = bitCnt_q + 4'd1;
        end else begin
            bitCnt_q = 4'd0;
            if (state_q == 3'd4) state_q = 3'd5;
            else if (state_q == 3'd5) begin
                ptr_q = ptr_q + 8'd1;
                if (sda) state_q = 3'd0;
            end
        end
    end
    // Line is released by default so the pull-up shows once the hold ends
    always @(negedge scl) if (state_q != 3'd0) begin
        holdLow = 1'b0;
        if (bitCnt_q == 4'd8 && state_q < 3'd4) begin
            holdLow = !mute && (state_q != 3'd1 || shift_q[7:4] == 4'b1010);
            if (!holdLow) state_q = 3'd0;
            else if (state_q == 3'd1) state_q = shift_q[0] ? 3'd4 : 3'd2;
            else if (state_q == 3'd2) begin
                ptr_q = shift_q;
                state_q = 3'd3;
            end else begin
                mem[ptr_q] = shift_q;
                ptr_q = ptr_q + 8'd1;
            end
        end else if (state_q == 3'd5 && bitCnt_q < 4'd8) begin
            holdLow = !mem[ptr_q][3'd7 - bitCnt_q[2:0]];
        end
    end
endmodule

// ===== dv/ecl_loader_bench.sv
// Purpose: Self-checking bench for the EEPROM configuration loader
// Assumes: Strap size code 0, all record bytes below address 8'h100
// Notes:   SCL period is 10 clocks, i.e. 250 ns
`timescale 1ns/1ps
module ecl_loader_bench;
    reg         clk, rst_n, mgmtWrReady, sdaGnd, mute, stall;
    wire        sdaOut, sdaOe, sclOut, sclOe, mgmtWrValid, eepromPresent, loadDone, loadError;
    wire        eeLow;
    wire [7:0]  mgmtWrAddr;
    wire [15:0] mgmtWrData;
    wire        sdaW = (sdaOe ? sdaOut : 1'b1) & ~eeLow & ~sdaGnd;
    wire        sclW = sclOe ? sclOut : 1'b1;
    integer     n_mismatch = 0, n_compared = 0, cyc = 0, i, r, k;
    reg [23:0]  rows [0:4];
    reg [23:0]  got [$];
    ecl_loader #(.QTR_CYC(2), .ACK_TO_CYC(2000)) dut_u (
        .clk(clk), .rst_n(rst_n), .strapAddr16(1'b0), .slaveSelectBits(3'd0),
        .strapSize(4'd0), .strapStep({4{stall}}), .strapRecordId({3{sdaGnd}}), .sdaIn(sdaW),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
        .mgmtWrValid(mgmtWrValid), .mgmtWrReady(mgmtWrReady), .mgmtWrAddr(mgmtWrAddr),
        .mgmtWrData(mgmtWrData), .eepromPresent(eepromPresent), .loadDone(loadDone),
        .loadError(loadError));
    ecl_eeprom_model ee_u (.scl(sclW), .sda(sdaW), .mute(mute), .holdLow(eeLow));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Stalled rows hold ready low for 25000 cycles, which ends before the 16-deep FIFO fills and before the loader has to wait in S_PUSH
    always @(negedge clk) mgmtWrReady <= !(stall && cyc < 25000);
    always @(posedge clk) begin
        cyc <= rst_n ? cyc + 1 : 0;
        if (rst_n && mgmtWrValid && mgmtWrReady) got.push_back({mgmtWrAddr, mgmtWrData});
    end
    task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Row: count byte, expected writes, flags {noPtr, mute, ground, stall}
    task setup(input [23:0] row);
        for (k = 0; k < 256; k = k + 1) ee_u.mem[k] = 8'hFF;
        {ee_u.mem[0], ee_u.mem[1], ee_u.mem[2], ee_u.mem[3]} = 32'hEEC0_DE1F;
        {ee_u.mem[4], ee_u.mem[5]} = 16'h0000;
        {ee_u.mem[6], ee_u.mem[7]} = row[3] ? 16'hFFFF : 16'h0020;
        ee_u.mem[8'h20] = row[23:16];
        for (k = 0; k < 20; k = k + 1) begin
            ee_u.mem[8'h21 + 3 * k] = k[7:0];
            ee_u.mem[8'h22 + 3 * k] = ~k[7:0];
            ee_u.mem[8'h23 + 3 * k] = k[7:0] + 8'h40;
        end
        {mute, sdaGnd, stall} = row[2:0];
        got.delete();
        {ee_u.holdLow, ee_u.state_q} = 4'h0;
    endtask
    task run_row(input [23:0] row);
        @(negedge clk) rst_n = 1'b0;
        setup(row);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (k = 0; k < 40000 && !((loadDone === 1'b1 || loadError === 1'b1)
            && mgmtWrValid !== 1'b1); k = k + 1) @(negedge clk);
        repeat (20) @(negedge clk);
        check(k < 40000, 1, "finish");
        check(got.size(), row[15:8], "count");
        for (i = 0; i < got.size(); i = i + 1)
            check(got[i], {i[7:0], ~i[7:0], i[7:0] + 8'h40}, "entry");
        check(eepromPresent, row[2:1] == 2'b00, "present");
        check(loadError, row[2], "error");
    endtask
    initial begin
        rst_n = 1'b0;
        {mute, sdaGnd, stall} = 3'b000;
        rows[0] = 24'h13_1401;
        rows[1] = 24'h00_0100;
        rows[2] = 24'h02_0008;
        rows[3] = 24'h02_0004;
        rows[4] = 24'h02_0002;
        for (r = 0; r < 5; r = r + 1) run_row(rows[r]);
        // Reset in mid-load must drop the entry stream at once
        rst_n = 1'b0;
        setup(rows[0]);
        @(negedge clk) rst_n = 1'b1;
        repeat (6000) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        check({mgmtWrValid, loadDone}, 0, "reset");
        run_row(rows[1]);
        finish_test;
    end
    // Rows take about 47000 cycles in all; the limit leaves margin
    initial begin
        repeat (95000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
endmodule
